//--- include/ssr_pkg.sv
// Function
// - Capture instructions in 8-bit register on clock rise
// - Instruction MSB first: one, address, opcode
// - Ignore input until first one after select
// - Select low clears instruction, aborts transfer
// - Shifting only on serial clock edges
// - Recall command or pin loads RAM, sets latch
// - Recalled latch clear after power-up recall
// - Writes and saves need recalled latch
// - Unlock latch gates writes; commands set, clear
// - Unlock latch cleared at power-up
// - Save only when unlocked and recalled
// - Save blocks port, recall and buffer, then clears unlock
// - Save within 5 ms, recall within 2 us
// - Arm command enables save on low supply
// - Open-drain flag low while supply low
// - Write opcode then sixteen data bits
// - Early deselect still writes shifted bits
// - Extra clocks keep shifting write data
// - Read returns addressed word, bit zero ignored
// - First read bit on eighth falling edge
// - Data output released except during read
// - Sixteen words of sixteen shadowed bits
// - Power-up recall ignores all instructions
// - Arming latch cleared at power-up
package ssr_pkg;

  // Opcodes in instruction bits 2..0
  localparam logic [2:0] OP_LOCK   = 3'h0;
  localparam logic [2:0] OP_SAVE   = 3'h1;
  localparam logic [2:0] OP_ARM    = 3'h2;
  localparam logic [2:0] OP_WRITE  = 3'h3;
  localparam logic [2:0] OP_UNLOCK = 3'h4;
  localparam logic [2:0] OP_RECALL = 3'h5;
  localparam logic [1:0] OP_READ_HI = 2'h3;

  // Frame layout, in serial clocks
  localparam int INSTR_BITS = 8;
  localparam int WORD_BITS  = 16;
  localparam int NUM_WORDS  = 16;
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] READ_FIRST = 5'h08;
  localparam logic [4:0] READ_LAST  = 5'h17;

  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int SAVE_TIME_US   = 5000;
  localparam int RECALL_TIME_NS = 2000;
  localparam int SAVE_CYC   = SAVE_TIME_US * CLK_MHZ;
  localparam int RECALL_CYC = RECALL_TIME_NS * CLK_MHZ / 1000;

  // Synchroniser idle value: recall pin high, others low
  localparam logic [4:0] SYNC_RST = 5'h08;

  typedef enum logic [2:0] {
    P_IDLE, P_INSTR, P_WDATA, P_RDATA, P_SKIP
  } ssr_phase_t;

endpackage : ssr_pkg

//--- src/ssr_port.sv
`timescale 1ns/1ps
module ssr_port #(
  parameter int WW       = ssr_pkg::WORD_BITS,
  parameter int NW       = ssr_pkg::NUM_WORDS,
  parameter int SAVE_CYC = ssr_pkg::SAVE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic select_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_in,
  input  wire logic recall_n_in,
  input  wire logic supply_low_in,
  output logic      serial_out,
  output logic      serial_out_oe_n,
  output logic      low_supply_flag_n,
  output logic      low_supply_flag_oe_n,
  output logic      write_unlocked,
  output logic      recall_seen,
  output logic      auto_save_armed,
  output logic      save_busy,
  output logic      recall_busy
);

  localparam int AW = $clog2(NW);
  localparam int RC = ssr_pkg::RECALL_CYC;
  localparam int CMAX = (SAVE_CYC > RC) ? SAVE_CYC : RC;
  localparam int CW = $clog2(CMAX + 1);
  localparam logic [CW-1:0] SAVE_END = CW'(SAVE_CYC - 1);
  localparam logic [CW-1:0] RCL_END  = CW'(RC - 1);

  typedef struct packed {
    logic [4:0]              sync1;
    logic [4:0]              sync2;
    logic [4:0]              sync3;
    logic [4:0]              filt;
    ssr_pkg::ssr_phase_t     phase;
    logic [7:0]              ir;
    logic [4:0]              cnt;
    logic [AW-1:0]           waddr;
    logic [WW-1:0]           wsh;
    logic [WW-1:0]           rsh;
    logic                    sdo;
    logic                    sdo_oe_n;
    logic                    flag_val;
    logic                    flag_oe_n;
    logic                    wel;
    logic                    prev;
    logic                    armed;
    logic                    pu;
    logic                    save_busy;
    logic                    rcl_busy;
    logic [CW-1:0]           tcnt;
    logic [1:0]              b_cnt;
    logic [1:0][AW-1:0]      b_addr;
    logic [1:0][WW-1:0]      b_data;
    logic [NW-1:0][WW-1:0]   ram;
    logic [NW-1:0][WW-1:0]   nv;
  } ssr_state_t;

  ssr_state_t state_reg;
  ssr_state_t state_next;

  logic          sel_now;
  logic          sck_rise;
  logic          sck_fall;
  logic          din;
  logic          busy;
  logic          push;
  logic          pop;
  logic          buf_rdy;
  logic          start_save;
  logic          start_rcl;
  logic [7:0]    ins;
  logic [1:0]    slot;

  // Filtered view of a pin: follows once stages two and three agree
  function automatic logic [4:0] ssr_filter(input logic [4:0] s2,
                                            input logic [4:0] s3,
                                            input logic [4:0] f);
    logic [4:0] o;
    o = f;
    for (int i = 0; i < 5; i++) begin
      if (s2[i] == s3[i]) begin
        o[i] = s3[i];
      end
    end
    return o;
  endfunction : ssr_filter

  // Whole block in one next-state process
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {supply_low_in, recall_n_in, serial_in,
                        serial_clock_in, select_in};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.filt  = ssr_filter(state_reg.sync2, state_reg.sync3,
                                  state_reg.filt);
    sel_now  = state_next.filt[0];
    din      = state_next.filt[2];
    // Edges only from the sampled clock; a stopped clock freezes shifting
    sck_rise = state_next.filt[1] & ~state_reg.filt[1];
    sck_fall = ~state_next.filt[1] & state_reg.filt[1];
    busy     = state_reg.save_busy | state_reg.rcl_busy;
    buf_rdy  = state_reg.b_cnt != 2'h2;
    push       = 1'b0;
    start_save = 1'b0;
    start_rcl  = 1'b0;
    ins  = {state_reg.ir[6:0], din};
    slot = 2'h0;

    // Serial front end
    if (!sel_now) begin
      // Early or late deselect commits the shifted word
      if (state_reg.phase == ssr_pkg::P_WDATA) begin
        push = state_reg.wel & state_reg.prev & buf_rdy;
      end
      state_next.phase    = ssr_pkg::P_IDLE;
      state_next.ir       = 8'h00;
      state_next.cnt      = 5'h00;
      state_next.sdo_oe_n = 1'b1;
    end else if (busy) begin
      // Frames that start during save or recall are dropped whole
      state_next.phase    = ssr_pkg::P_SKIP;
      state_next.sdo_oe_n = 1'b1;
    end else begin
      case (state_reg.phase)
        ssr_pkg::P_IDLE: begin
          // Zeros before the start bit are line idle
          if (sck_rise && din) begin
            state_next.ir    = 8'h01;
            state_next.cnt   = 5'h01;
            state_next.phase = ssr_pkg::P_INSTR;
          end
        end
        ssr_pkg::P_INSTR: begin
          if (sck_rise) begin
            state_next.ir  = ins;
            state_next.cnt = state_reg.cnt + 5'h01;
            if (state_reg.cnt == ssr_pkg::INSTR_LAST) begin
              state_next.phase = ssr_pkg::P_SKIP;
              if (ins[2:1] == ssr_pkg::OP_READ_HI) begin
                state_next.rsh   = state_reg.ram[ins[6:3]];
                state_next.cnt   = ssr_pkg::READ_FIRST;
                state_next.phase = ssr_pkg::P_RDATA;
              end else begin
                case (ins[2:0])
                  ssr_pkg::OP_WRITE: begin
                    state_next.waddr = ins[6:3];
                    state_next.wsh   = '0;
                    state_next.phase = ssr_pkg::P_WDATA;
                  end
                  ssr_pkg::OP_LOCK: begin
                    state_next.wel = 1'b0;
                  end
                  ssr_pkg::OP_UNLOCK: begin
                    state_next.wel = 1'b1;
                  end
                  ssr_pkg::OP_ARM: begin
                    state_next.armed = 1'b1;
                  end
                  ssr_pkg::OP_SAVE: begin
                    start_save = state_reg.wel & state_reg.prev;
                  end
                  ssr_pkg::OP_RECALL: begin
                    start_rcl = 1'b1;
                  end
                  default: begin
                    state_next.phase = ssr_pkg::P_SKIP;
                  end
                endcase
              end
            end
          end
        end
        ssr_pkg::P_WDATA: begin
          // Past sixteen bits the oldest bits fall off the top
          if (sck_rise) begin
            state_next.wsh = {state_reg.wsh[WW-2:0], din};
          end
        end
        ssr_pkg::P_RDATA: begin
          if (sck_fall && state_reg.sdo_oe_n &&
              state_reg.cnt == ssr_pkg::READ_FIRST) begin
            state_next.sdo      = state_reg.rsh[WW-1];
            state_next.rsh      = {state_reg.rsh[WW-2:0], 1'b0};
            state_next.sdo_oe_n = 1'b0;
          end else if (sck_rise && !state_reg.sdo_oe_n) begin
            if (state_reg.cnt == ssr_pkg::READ_LAST) begin
              state_next.sdo_oe_n = 1'b1;
              state_next.phase    = ssr_pkg::P_SKIP;
            end else begin
              state_next.sdo = state_reg.rsh[WW-1];
              state_next.rsh = {state_reg.rsh[WW-2:0], 1'b0};
              state_next.cnt = state_reg.cnt + 5'h01;
            end
          end
        end
        ssr_pkg::P_SKIP: begin
          state_next.phase = ssr_pkg::P_SKIP;
        end
        default: begin
          state_next.phase = ssr_pkg::P_IDLE;
        end
      endcase
    end

    // Hardware recall on the pin's falling edge
    if (!state_next.filt[3] && state_reg.filt[3] && !busy) begin
      start_rcl = 1'b1;
    end
    // Automatic save needs arming, unlock and recalled latches set again after power-up
    if (state_next.filt[4] && !state_reg.filt[4] && !busy &&
        state_reg.armed && state_reg.wel && state_reg.prev) begin
      start_save = 1'b1;
    end
    state_next.flag_oe_n = ~state_next.filt[4];

    // Two-entry write buffer; RAM side stalls while a transfer runs
    pop = (state_reg.b_cnt != 2'h0) && !busy;
    if (pop) begin
      state_next.ram[state_reg.b_addr[0]] = state_reg.b_data[0];
      state_next.b_addr[0] = state_reg.b_addr[1];
      state_next.b_data[0] = state_reg.b_data[1];
    end
    slot = state_reg.b_cnt - {1'b0, pop};
    if (push) begin
      state_next.b_addr[slot[0]] = state_reg.waddr;
      state_next.b_data[slot[0]] = state_reg.wsh;
    end
    state_next.b_cnt = slot + {1'b0, push};

    // Transfers between RAM and shadow cells, with busy timers
    if (start_save) begin
      state_next.nv        = state_next.ram;
      state_next.save_busy = 1'b1;
      state_next.tcnt      = '0;
    end else if (start_rcl) begin
      state_next.ram      = state_reg.nv;
      state_next.prev     = 1'b1;
      state_next.rcl_busy = 1'b1;
      state_next.tcnt     = '0;
    end else if (state_reg.save_busy) begin
      state_next.tcnt = state_reg.tcnt + CW'(1);
      if (state_reg.tcnt == SAVE_END) begin
        state_next.save_busy = 1'b0;
        state_next.wel       = 1'b0;
      end
    end else if (state_reg.rcl_busy) begin
      state_next.tcnt = state_reg.tcnt + CW'(1);
      if (state_reg.tcnt == RCL_END) begin
        state_next.rcl_busy = 1'b0;
        state_next.pu       = 1'b0;
      end
    end

    // Power-up: latches clear, shadow kept, recall runs at once
    if (reset) begin
      state_next          = '0;
      state_next.sync1    = ssr_pkg::SYNC_RST;
      state_next.sync2    = ssr_pkg::SYNC_RST;
      state_next.sync3    = ssr_pkg::SYNC_RST;
      state_next.filt     = ssr_pkg::SYNC_RST;
      state_next.phase    = ssr_pkg::P_IDLE;
      state_next.nv       = state_reg.nv;
      state_next.ram      = state_reg.nv;
      state_next.sdo_oe_n = 1'b1;
      state_next.flag_oe_n = 1'b1;
      state_next.rcl_busy = 1'b1;
      state_next.pu       = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
  end

  // Outputs straight from state flops
  assign serial_out           = state_reg.sdo;
  assign serial_out_oe_n      = state_reg.sdo_oe_n;
  assign low_supply_flag_n    = state_reg.flag_val;
  assign low_supply_flag_oe_n = state_reg.flag_oe_n;
  assign write_unlocked       = state_reg.wel;
  assign recall_seen          = state_reg.prev;
  assign auto_save_armed      = state_reg.armed;
  assign save_busy            = state_reg.save_busy;
  assign recall_busy          = state_reg.rcl_busy;

  default clocking ssr_cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  ir_clear_a: assert property (
    !sel_now |=> state_reg.ir == 8'h00 &&
                 state_reg.phase == ssr_pkg::P_IDLE)
    else $error("instruction not cleared on deselect");

  save_gate_a: assert property (
    $rose(state_reg.save_busy) |->
      $past(state_reg.prev) && $past(state_reg.wel))
    else $error("save started while locked");

  save_end_a: assert property (
    $fell(state_reg.save_busy) |-> !state_reg.wel)
    else $error("unlock latch survived a save");

  pu_latch_a: assert property (
    state_reg.pu |-> !state_reg.prev && state_reg.rcl_busy)
    else $error("recalled latch set by power-up recall");

  write_gate_a: assert property (
    push |-> state_reg.prev && state_reg.wel)
    else $error("write accepted while locked");

  block_busy_a: assert property (
    state_reg.save_busy && sel_now |=>
      state_reg.phase == ssr_pkg::P_SKIP && state_reg.sdo_oe_n)
    else $error("serial port active during save");

  recall_len_a: assert property (
    $rose(state_reg.rcl_busy) && !state_reg.pu |->
      state_reg.rcl_busy [*8] ##[1:400] !state_reg.rcl_busy)
    else $error("recall length wrong");

  read_start_a: assert property (
    $fell(state_reg.sdo_oe_n) |->
      $past(sck_fall) && state_reg.cnt == ssr_pkg::READ_FIRST)
    else $error("read data launched on wrong edge");

  sdo_hiz_a: assert property (
    state_reg.phase != ssr_pkg::P_RDATA |-> state_reg.sdo_oe_n)
    else $error("data output driven outside read");

  flag_follow_a: assert property (
    $rose(state_reg.filt[4]) |=> !low_supply_flag_oe_n)
    else $error("low supply flag not asserted");

endmodule : ssr_port

//--- sim/ssr_host.sv
`timescale 1ns/1ps
// Host side of the serial port
module ssr_host (
  output logic      select_in,
  output logic      serial_clock_in,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  localparam time HALF = 32ns;

  // Link clock stands low between frames
  initial begin
    select_in = 1'b0;
    serial_clock_in = 1'b0;
    serial_in = 1'b0;
  end

  // One link clock; read data sampled just before the rise, X if released
  task automatic tick(input logic b, output logic q);
    serial_in = b;
    #(HALF);
    q = serial_out_oe_n ? 1'bx : serial_out;
    serial_clock_in = 1'b1;
    #(HALF);
    serial_clock_in = 1'b0;
  endtask : tick

  // Lead zeros, ni instruction bits, nd data bits, all MSB first
  task automatic frame(input int lead, input int ni, input logic [7:0] ins,
                       input logic [31:0] wd, input int nd,
                       output logic [15:0] rd);
    logic q;
    rd = 16'h0000;
    select_in = 1'b1;
    #(HALF);
    for (int i = 0; i < lead; i++) tick(1'b0, q);
    for (int i = 7; i >= 8 - ni; i--) tick(ins[i], q);
    for (int i = nd - 1; i >= 0; i--) begin
      tick(wd[i], q);
      rd = {rd[14:0], q};
    end
    select_in = 1'b0;
    // Released line must not keep showing the last bit
    serial_in = ~serial_in;
    #(HALF * 2);
  endtask : frame
endmodule : ssr_host

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int SAVE_N = 600;
  logic        sys_clk;
  logic        reset;
  logic        recall_n_in;
  logic        supply_low_in;
  wire         select_in, serial_clock_in, serial_in, serial_out;
  wire         serial_out_oe_n, low_supply_flag_n, low_supply_flag_oe_n;
  wire         write_unlocked, recall_seen, auto_save_armed;
  wire         save_busy, recall_busy;
  int          fails;
  int          tests_run;
  integer      seed;
  int          n;
  logic [15:0] mem [16];
  logic [15:0] nv [16];
  logic [15:0] d;
  logic [15:0] q;
  logic [31:0] w;

  // Short save time keeps the run brief
  ssr_port #(.SAVE_CYC(SAVE_N)) dut (
    .sys_clk, .reset, .select_in, .serial_clock_in, .serial_in,
    .recall_n_in, .supply_low_in, .serial_out, .serial_out_oe_n,
    .low_supply_flag_n, .low_supply_flag_oe_n, .write_unlocked,
    .recall_seen, .auto_save_armed, .save_busy, .recall_busy
  );

  ssr_host host (
    .select_in, .serial_clock_in, .serial_in, .serial_out,
    .serial_out_oe_n
  );

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Don't-care address bits are random
  task automatic cmd(input logic [2:0] op);
    logic [7:0] r;
    r = 8'($random(seed));
    host.frame(0, 8, {1'b1, r[3:0], op}, 32'h0, 0, q);
    cyc(1);
  endtask : cmd

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input int k);
    host.frame(0, 8, {1'b1, a, ssr_pkg::OP_WRITE}, v, k, q);
    cyc(1);
  endtask : wr

  // Random lead zeros and random bit 0 on every read
  task automatic rdw(input logic [3:0] a, input logic [15:0] exp);
    logic [7:0] r;
    r = 8'($random(seed));
    host.frame(int'(r[1:0]), 8, {1'b1, a, ssr_pkg::OP_READ_HI, r[7]},
               32'h0, 16, q);
    check("read_word", q, exp);
    check("out_released", 16'(serial_out_oe_n), 16'h1);
    cyc(1);
  endtask : rdw

  // Bounded wait for save and recall to finish
  task automatic idle;
    n = 0;
    while ((save_busy | recall_busy) !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    // A hang here ends the run as a failure
    if (n >= 2000) begin
      fails++;
      conclude;
    end
  endtask : idle

  task automatic por;
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
  endtask : por

  task automatic conclude;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // Watchdog well past the expected run time
  initial begin
    #(400us);
    fails++;
    conclude;
  end

  initial begin
    seed = 32'hd9ec;
    fails = 0;
    tests_run = 0;
    reset = 1'b1;
    recall_n_in = 1'b1;
    supply_low_in = 1'b0;
    por;
    check("pwrup", {write_unlocked, recall_seen, auto_save_armed, save_busy,
          serial_out_oe_n, low_supply_flag_oe_n, recall_busy}, 16'h7);
    cmd(ssr_pkg::OP_UNLOCK);
    check("unlock_ignored", 16'(write_unlocked), 16'h0);
    idle;
    cmd(ssr_pkg::OP_UNLOCK);
    check("unlock", 16'(write_unlocked), 16'h1);
    cmd(ssr_pkg::OP_SAVE);
    check("save_no_recall", 16'(save_busy), 16'h0);
    cmd(ssr_pkg::OP_RECALL);
    check("recall", {recall_seen, recall_busy}, 16'h3);
    idle;
    check("recall_time", 16'(n <= 400), 16'h1);
    for (int a = 0; a < 16; a++) begin
      d = 16'($random(seed));
      mem[a] = d;
      wr(4'(a), {16'h0, d}, 16);
    end
    for (int a = 15; a >= 0; a--) rdw(4'(a), mem[a]);
    nv = mem;
    // Save, with a write that must be ignored while it runs
    cmd(ssr_pkg::OP_SAVE);
    check("save_start", 16'(save_busy), 16'h1);
    wr(4'h0, {16'h0, ~mem[0]}, 16);
    idle;
    check("save_time", 16'(n < SAVE_N), 16'h1);
    check("save_relock", 16'(write_unlocked), 16'h0);
    rdw(4'h0, mem[0]);
    cmd(ssr_pkg::OP_UNLOCK);
    cmd(ssr_pkg::OP_LOCK);
    check("lock", 16'(write_unlocked), 16'h0);
    wr(4'h1, {16'h0, ~mem[1]}, 16);
    rdw(4'h1, mem[1]);
    cmd(ssr_pkg::OP_SAVE);
    check("save_locked", 16'(save_busy), 16'h0);
    // Short, overlong and aborted transfers
    cmd(ssr_pkg::OP_UNLOCK);
    w = $random(seed);
    wr(4'h2, w, 8);
    wr(4'h4, w, 28);
    host.frame(0, 5, {1'b1, 4'h2, 3'h3}, 32'h0, 0, q);
    rdw(4'h2, {8'h00, w[7:0]});
    rdw(4'h4, w[15:0]);
    por;
    idle;
    check("latches", {recall_seen, write_unlocked}, 16'h0);
    rdw(4'h2, nv[2]);
    cmd(ssr_pkg::OP_UNLOCK);
    wr(4'h5, {16'h0, ~nv[5]}, 16);
    rdw(4'h5, nv[5]);
    recall_n_in = 1'b0;
    cyc(4);
    recall_n_in = 1'b1;
    cyc(4);
    check("pin_recall", {recall_seen, recall_busy}, 16'h3);
    idle;
    // Supply loss with the automatic save armed
    cmd(ssr_pkg::OP_ARM);
    check("armed", 16'(auto_save_armed), 16'h1);
    d = 16'($random(seed));
    wr(4'h6, {16'h0, d}, 16);
    supply_low_in = 1'b1;
    cyc(6);
    check("low_flag", {low_supply_flag_oe_n, low_supply_flag_n, save_busy},
          16'h1);
    idle;
    supply_low_in = 1'b0;
    cyc(6);
    check("flag_off", 16'(low_supply_flag_oe_n), 16'h1);
    por;
    idle;
    check("arm_cleared", 16'(auto_save_armed), 16'h0);
    rdw(4'h6, d);
    conclude;
  end
endmodule : tb_top
